//--- include/pspc_pkg.sv
// Shared widths, reset values and state codes for the SRAM port control.
package pspc_pkg;

    // ========================================================================
    // Widths and sizes.
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int PAR_W = 4;
    localparam int BURST_W = 2;
    localparam int MEM_DEPTH = 65536;

    // ========================================================================
    // Reset values and settle count.
    localparam logic SYNC_RST = 1'b0;
    localparam logic OE_N_RST = 1'b1;
    localparam logic MODE_LINEAR = 1'b0;
    localparam logic MODE_INTERLEAVED = 1'b1;
    localparam logic [1:0] SETTLE_DONE = 2'h3;
    localparam logic [1:0] BURST_RST = 2'h0;

    // ========================================================================
    // Port states.
    typedef enum logic [1:0] {
        PS_IDLE,
        PS_DESEL,
        PS_READ,
        PS_WRITE
    } pspc_state_t;

endpackage

//--- include/pspc_link_if.sv
// Interface joining the port control to its burst counter and word memory.
`timescale 1ns/10ps
interface pspc_link_if #(
    parameter int ADDR_W = pspc_pkg::ADDR_W,
    parameter int WORD_W = pspc_pkg::DATA_W + pspc_pkg::PAR_W
) (
    input wire logic clk,
    input wire logic rst
);
    logic en;
    logic [ADDR_W-1:0] rd_addr;
    logic [WORD_W-1:0] rd_data;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [WORD_W-1:0] wr_data;
    logic b_load;
    logic [pspc_pkg::BURST_W-1:0] b_load_val;
    logic b_step;
    logic b_mode;
    logic [pspc_pkg::BURST_W-1:0] b_next;

    modport mem (input clk, en, rd_addr, wr_en, wr_addr, wr_data,
        output rd_data);
    modport burst (input clk, rst, en, b_load, b_load_val, b_step, b_mode,
        output b_next);
endinterface

//--- logic/pspc_word_mem.sv
// Word memory with registered read data.
`timescale 1ns/10ps
module pspc_word_mem #(
    parameter int ADDR_W = pspc_pkg::ADDR_W,
    parameter int WORD_W = pspc_pkg::DATA_W + pspc_pkg::PAR_W,
    parameter int DEPTH = pspc_pkg::MEM_DEPTH
) (
    pspc_link_if.mem port
);
    typedef struct packed {
        logic [WORD_W-1:0] rd_data;
    } pspc_mem_st_t;

    logic [WORD_W-1:0] cells [DEPTH];
    pspc_mem_st_t st;
    pspc_mem_st_t next_st;

    // ========================================================================
    // Read register and write port.
    always_comb
    begin
        next_st = st;
        next_st.rd_data = cells[port.rd_addr];
    end

    always_ff @(posedge port.clk)
    begin
        if (port.en)
        begin
            st <= next_st;
            if (port.wr_en)
            begin
                cells[port.wr_addr] <= port.wr_data;
            end
        end
    end

    assign port.rd_data = st.rd_data;
endmodule

//--- logic/pspc_burst_ctr.sv
// Two-bit wrapping burst counter with linear or interleaved order.
`timescale 1ns/10ps
module pspc_burst_ctr (
    pspc_link_if.burst port
);
    typedef struct packed {
        logic [pspc_pkg::BURST_W-1:0] first;
        logic [pspc_pkg::BURST_W-1:0] count;
    } pspc_burst_st_t;

    pspc_burst_st_t st;
    pspc_burst_st_t next_st;

    // ========================================================================
    // Counter step and order.
    always_comb
    begin
        next_st = st;
        if (port.b_load)
        begin
            next_st.first = port.b_load_val;
            next_st.count = pspc_pkg::BURST_RST;
        end
        else if (port.b_step)
        begin
            next_st.count = st.count + 2'h1;
        end
    end

    always_ff @(posedge port.clk)
    begin
        if (port.rst)
        begin
            st <= '0;
        end
        else if (port.en)
        begin
            st <= next_st;
        end
    end

    // Interleaved exclusive-ors the offset, linear adds it.
    assign port.b_next = (port.b_mode == pspc_pkg::MODE_INTERLEAVED) ?
        (next_st.first ^ next_st.count) :
        2'(next_st.first + next_st.count);

    // ========================================================================
    // Checks.
    chk_burst_wrap: assert property (@(posedge port.clk) disable iff (port.rst)
        port.en && !port.b_load && port.b_step && st.count == 2'h3
        |=> st.count == 2'h0)
        else $error("Burst counter did not wrap after fourth address.");
endmodule

//--- logic/pspc_port_ctrl.sv
// Host port control of a pipelined synchronous SRAM with common data bus.
//
// Behaviour
// - Sample active-high second select each edge for the select decision.
// - Sample active-low third select each edge for the select decision.
// - Output enable low drives data and parity pins; high makes them inputs.
// - First read clock after deselect keeps outputs off regardless of enable.
// - Burst step low at an edge during a burst advances the burst address.
// - Either accepted address strobe captures the full address bus.
// - An accepted strobe loads the two low address bits into the counter.
// - Both strobes low together: processor strobe wins, controller ignored.
// - Processor strobe ignored while first select is high.
// - Sleep high freezes activity but memory contents are kept.
// - Sleep held low or open for normal work; open reads as low.
// - Data and parity pins are captured into a data register each edge.
// - Read data of the address taken at the previous edge is driven out.
// - Strap low gives linear order, high or open gives interleaved.
// - Selected only with first and third selects low and second high.
// - Sixty-four thousand words; capture needs a strobe and all selects.
// - Two-bit burst counter starts from low address bits and wraps.
`timescale 1ns/10ps
module pspc_port_ctrl #(
    parameter int ADDR_W = pspc_pkg::ADDR_W,
    parameter int DATA_W = pspc_pkg::DATA_W,
    parameter int PAR_W = pspc_pkg::PAR_W,
    parameter int DEPTH = pspc_pkg::MEM_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic select_a_n_in,
    input wire logic select_b_in,
    input wire logic select_c_n_in,
    input wire logic proc_addr_strobe_n_in,
    input wire logic ctrl_addr_strobe_n_in,
    input wire logic burst_step_n_in,
    input wire logic write_all_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] data_io_in,
    input wire logic [PAR_W-1:0] parity_io_in,
    input wire logic output_en_n_in,
    input wire logic sleep_req_in,
    input wire logic burst_mode_in,
    output logic [DATA_W-1:0] data_io_out,
    output logic [PAR_W-1:0] parity_io_out,
    output logic data_oe_out,
    output logic sleeping_out
);
    localparam int WORD_W = DATA_W + PAR_W;

    typedef struct packed {
        logic sleep_s1;
        logic sleep_s2;
        logic oe_n_s1;
        logic oe_n_s2;
        logic mode_s1;
        logic mode_s2;
        logic [1:0] settle;
        logic mode;
        pspc_pkg::pspc_state_t state;
        logic [ADDR_W-1:0] addr;
        logic wr_pend;
        logic [ADDR_W-1:0] wr_addr;
        logic [WORD_W-1:0] din;
        logic rd_pend;
        logic mask;
        logic drive;
        logic [WORD_W-1:0] dout;
    } pspc_top_st_t;

    pspc_top_st_t st;
    pspc_top_st_t next_st;
    logic run;
    logic selected;
    logic proc_ok;
    logic strobe;
    logic start;
    logic desel;
    logic start_wr;
    logic cont;
    logic wr_go;
    logic rd_go;
    logic [ADDR_W-1:0] rd_addr;

    pspc_link_if #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) lnk (
        .clk(clk_in),
        .rst(rst_in)
    );

    // ========================================================================
    // Burst counter and word memory.
    pspc_burst_ctr u_burst (
        .port(lnk.burst)
    );

    pspc_word_mem #(.ADDR_W(ADDR_W), .WORD_W(WORD_W), .DEPTH(DEPTH)) u_mem (
        .port(lnk.mem)
    );

    assign lnk.en = ce_in;
    assign lnk.b_load = start;
    assign lnk.b_load_val = addr_in[pspc_pkg::BURST_W-1:0];
    assign lnk.b_step = cont && !burst_step_n_in;
    assign lnk.b_mode = st.mode;
    assign lnk.wr_en = st.wr_pend;
    assign lnk.wr_addr = st.wr_addr;
    assign lnk.wr_data = st.din;
    assign rd_addr = {start ? addr_in[ADDR_W-1:pspc_pkg::BURST_W] :
        st.addr[ADDR_W-1:pspc_pkg::BURST_W], lnk.b_next};
    assign lnk.rd_addr = rd_addr;

    // ========================================================================
    // Next state.
    always_comb
    begin
        next_st = st;
        next_st.sleep_s1 = sleep_req_in;
        next_st.sleep_s2 = st.sleep_s1;
        next_st.oe_n_s1 = output_en_n_in;
        next_st.oe_n_s2 = st.oe_n_s1;
        next_st.mode_s1 = burst_mode_in;
        next_st.mode_s2 = st.mode_s1;
        // The strap is copied on each of the first three edges after reset and then held.
        if (st.settle != pspc_pkg::SETTLE_DONE)
        begin
            next_st.settle = st.settle + 2'h1;
            next_st.mode = st.mode_s2;
        end
        run = !st.sleep_s2;
        selected = !select_a_n_in && select_b_in
            && !select_c_n_in;
        proc_ok = !proc_addr_strobe_n_in && !select_a_n_in;
        strobe = proc_ok || !ctrl_addr_strobe_n_in;
        start = run && strobe && selected;
        desel = run && strobe && !selected;
        start_wr = start && !proc_ok && !write_all_n_in;
        case (st.state)
            pspc_pkg::PS_READ, pspc_pkg::PS_WRITE:
            begin
                cont = run && !strobe;
            end
            pspc_pkg::PS_IDLE, pspc_pkg::PS_DESEL:
            begin
                cont = 1'b0;
            end
            default:
            begin
                cont = 1'b0;
            end
        endcase
        wr_go = start_wr || (cont && !write_all_n_in);
        rd_go = (start && !start_wr) || (cont && write_all_n_in);
        if (start)
        begin
            next_st.addr = addr_in;
        end
        if (rd_go)
        begin
            next_st.state = pspc_pkg::PS_READ;
        end
        else if (wr_go)
        begin
            next_st.state = pspc_pkg::PS_WRITE;
        end
        else if (desel)
        begin
            next_st.state = pspc_pkg::PS_DESEL;
        end
        next_st.wr_pend = wr_go;
        next_st.wr_addr = rd_addr;
        next_st.din = {parity_io_in, data_io_in};
        next_st.rd_pend = rd_go;
        next_st.mask = start && !start_wr
            && (st.state == pspc_pkg::PS_IDLE
            || st.state == pspc_pkg::PS_DESEL);
        if (st.rd_pend)
        begin
            next_st.dout = lnk.rd_data;
        end
        next_st.drive = run && !st.oe_n_s2 && !desel && !next_st.mask
            && next_st.state == pspc_pkg::PS_READ;
    end

    // ========================================================================
    // State register.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st <= '0;
            st.oe_n_s1 <= pspc_pkg::OE_N_RST;
            st.oe_n_s2 <= pspc_pkg::OE_N_RST;
            st.mode_s1 <= pspc_pkg::MODE_INTERLEAVED;
            st.mode_s2 <= pspc_pkg::MODE_INTERLEAVED;
            st.mode <= pspc_pkg::MODE_INTERLEAVED;
            st.sleep_s1 <= pspc_pkg::SYNC_RST;
            st.sleep_s2 <= pspc_pkg::SYNC_RST;
            st.state <= pspc_pkg::PS_IDLE;
        end
        else if (ce_in)
        begin
            st <= next_st;
        end
    end

    // ========================================================================
    // Outputs.
    assign data_io_out = st.dout[DATA_W-1:0];
    assign parity_io_out = st.dout[WORD_W-1:DATA_W];
    assign data_oe_out = st.drive;
    assign sleeping_out = st.sleep_s2;

    // ========================================================================
    // Checks.
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    chk_select_decode: assert property (
        ce_in && run && !ctrl_addr_strobe_n_in && select_c_n_in
        |=> st.state == pspc_pkg::PS_DESEL)
        else $error("Inactive third select did not deselect.");

    chk_select_high: assert property (
        ce_in && run && !ctrl_addr_strobe_n_in && !select_b_in
        |=> st.state == pspc_pkg::PS_DESEL && !data_oe_out)
        else $error("Low second select did not deselect.");

    chk_addr_capture: assert property (
        ce_in && !rst_in && start |=> st.addr == $past(addr_in))
        else $error("Address not captured on accepted strobe.");

    chk_proc_gate: assert property (
        ce_in && select_a_n_in && ctrl_addr_strobe_n_in
        |=> $stable(st.addr))
        else $error("Processor strobe accepted with first select high.");

    chk_proc_priority: assert property (
        ce_in && start && !proc_addr_strobe_n_in && !write_all_n_in
        |=> !st.wr_pend && st.state == pspc_pkg::PS_READ)
        else $error("Controller strobe not ignored beside processor.");

    chk_burst_load: assert property (
        ce_in && start
        |-> rd_addr[1:0] == addr_in[1:0])
        else $error("Burst did not start at the low address bits.");

    chk_burst_linear: assert property (
        ce_in && cont && !burst_step_n_in
        && st.mode == pspc_pkg::MODE_LINEAR
        |-> rd_addr[1:0] == 2'(st.wr_addr[1:0] + 2'h1))
        else $error("Linear burst did not advance by one.");

    chk_burst_inter: assert property (
        ce_in && start && st.mode == pspc_pkg::MODE_INTERLEAVED
        ##1 ce_in && cont && !burst_step_n_in
        |-> rd_addr[1:0] == (st.wr_addr[1:0] ^ 2'h1))
        else $error("Interleaved burst second address wrong.");

    chk_oe_mask: assert property (
        ce_in && start && !start_wr && st.state == pspc_pkg::PS_DESEL
        |=> !data_oe_out)
        else $error("Outputs driven on first read after deselect.");

    chk_oe_release: assert property (
        ce_in && st.oe_n_s2 |=> !data_oe_out)
        else $error("Outputs driven while output enable is high.");

    chk_write_tristate: assert property (
        ce_in && !rst_in && wr_go |=> !data_oe_out)
        else $error("Outputs driven during a write cycle.");

    chk_read_pipe: assert property (
        ce_in && st.rd_pend |=> st.dout == $past(lnk.rd_data))
        else $error("Read data not moved to the output register.");

    chk_data_capture: assert property (
        ce_in && !rst_in
        |=> st.din == $past({parity_io_in, data_io_in}))
        else $error("Input data not captured.");

    chk_sleep_hold: assert property (
        ce_in && st.sleep_s2
        |=> $stable(st.addr) && $stable(st.state) && !data_oe_out)
        else $error("Port state moved during sleep.");

    chk_mode_static: assert property (
        st.settle == pspc_pkg::SETTLE_DONE |=> $stable(st.mode))
        else $error("Burst order changed after it was taken.");

    cov_read_start: cover property (ce_in && start && !start_wr);
    cov_write_start: cover property (ce_in && start_wr);
    cov_burst_run: cover property ((ce_in && cont && !burst_step_n_in)[*3]);
    cov_masked_read: cover property (ce_in && next_st.mask);
    cov_sleep_entry: cover property ($rose(st.sleep_s2));
endmodule

//--- verification/pspc_host_model.sv
// Far-side bus model that resolves the shared data and parity wires.
`timescale 1ns/10ps
module pspc_host_model (
    input wire logic clk_in,
    input wire logic drive_in,
    input wire logic [35:0] word_in,
    input wire logic dev_oe_in,
    input wire logic [35:0] dev_word_in,
    output logic [35:0] wire_out
);
    logic [35:0] last = 36'h000000000;

    // ========================================================================
    // Wire level: a released bus shows a pattern that changes every cycle.
    always_comb
    begin
        if (dev_oe_in && drive_in)
            wire_out = 'x;
        else if (dev_oe_in)
            wire_out = dev_word_in;
        else if (drive_in)
            wire_out = word_in;
        else
            wire_out = ~last;
    end

    always_ff @(posedge clk_in)
    begin
        last <= wire_out;
    end
endmodule

//--- verification/testbench.sv
// Self-checking bench for the SRAM host port control.
`timescale 1ns/10ps
module testbench;
    typedef struct {int at; logic [36:0] val; logic [36:0] msk;} pspc_note_t;
    localparam logic [36:0] M_OE = 37'h1000000000;
    localparam logic [36:0] M_DQ = 37'h0fffffffff;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic a_n = 1'b0, sel_b = 1'b1, c_n = 1'b0, ps_n = 1'b1, cs_n = 1'b1;
    logic st_n = 1'b1, wr_n = 1'b1, oe_n = 1'b0, slp = 1'b0, mode = 1'b1;
    logic hdrv = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [35:0] hword = 36'h000000000;
    logic [35:0] dq;
    logic [31:0] dout;
    logic [3:0] pout;
    logic doe, sleeping;
    logic [35:0] mem [int];
    pspc_note_t notes [$];
    int edges = 0;
    int miscompares = 0;
    int tests_run = 0;
    integer seed = 32'h08ac6730;

    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) edges <= edges + 1;

    pspc_port_ctrl pspc_port_ctrl_i (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
        .select_a_n_in(a_n), .select_b_in(sel_b), .select_c_n_in(c_n),
        .proc_addr_strobe_n_in(ps_n), .ctrl_addr_strobe_n_in(cs_n),
        .burst_step_n_in(st_n), .write_all_n_in(wr_n), .addr_in(addr),
        .data_io_in(dq[31:0]), .parity_io_in(dq[35:32]),
        .output_en_n_in(oe_n), .sleep_req_in(slp), .burst_mode_in(mode),
        .data_io_out(dout), .parity_io_out(pout), .data_oe_out(doe),
        .sleeping_out(sleeping));

    pspc_host_model pspc_host_model_i (
        .clk_in(clk_in), .drive_in(hdrv), .word_in(hword), .dev_oe_in(doe),
        .dev_word_in({pout, dout}), .wire_out(dq));

    // ========================================================================
    // Comparison, notes and closing report.
    task automatic check(input logic [36:0] seen, input logic [36:0] exp,
        input logic [36:0] m);
        tests_run++;
        if ((seen & m) !== (exp & m))
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic expect_at(input int dt, input logic [36:0] v,
        input logic [36:0] m);
        notes.push_back('{edges + dt, v, m});
    endtask

    always @(negedge clk_in)
    begin
        for (int i = notes.size() - 1; i >= 0; i--)
            if (notes[i].at == edges)
            begin
                check({doe, pout, dout}, notes[i].val, notes[i].msk);
                notes.delete(i);
            end
    end

    task automatic end_of_test();
        $display("compares %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ========================================================================
    // Bus cycles.
    task automatic drive(input logic p, input logic c, input logic s,
        input logic w, input logic [15:0] a, input logic [2:0] sel = 3'b010);
        @(posedge clk_in);
        ps_n <= p;
        cs_n <= c;
        st_n <= s;
        wr_n <= w;
        addr <= a;
        a_n <= sel[2];
        sel_b <= sel[1];
        c_n <= sel[0];
        hdrv <= p && !w;
    endtask

    task automatic do_reset(input logic m);
        @(posedge clk_in);
        rst_in <= 1'b1;
        mode <= m;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        check({35'h0, doe, sleeping}, 37'h0, '1);
    endtask

    task automatic write_word(input logic [15:0] a, input logic [35:0] w);
        drive(1'b1, 1'b0, 1'b1, 1'b0, a);
        hword <= w;
        mem[a] = w;
        expect_at(2, 37'h0, M_OE);
    endtask

    task automatic read_word(input logic [15:0] a, input logic fresh);
        drive(1'b0, 1'b1, 1'b1, 1'b1, a);
        if (fresh)
            expect_at(2, 37'h0, M_OE);
        expect_at(3, {1'b1, mem[a]}, '1);
    endtask

    task automatic burst(input logic [15:0] a, input logic lin);
        logic [15:0] b;
        read_word(a, 1'b0);
        for (int i = 1; i <= 4; i++)
        begin
            b = {a[15:2], lin ? a[1:0] + 2'(i) : a[1:0] ^ 2'(i)};
            drive(1'b1, 1'b1, 1'b0, 1'b1, a);
            expect_at(3, {1'b1, mem[b]}, '1);
        end
        drive(1'b1, 1'b1, 1'b1, 1'b1, a);
    endtask

    task automatic wait_sleep(input logic lvl);
        int n;
        n = 0;
        while (sleeping !== lvl && n < 10)
        begin
            @(posedge clk_in);
            n++;
        end
        if (n == 10)
        begin
            miscompares++;
            end_of_test();
        end
    endtask

    // ========================================================================
    // Main sequence.
    initial
    begin
        logic [15:0] base;
        logic [15:0] other;
        base = 16'($random(seed)) & 16'hfff0;
        other = base ^ 16'h0100;
        do_reset(1'b1);
        for (int i = 0; i < 4; i++)
            write_word(base + 16'(i), 36'({$random(seed), $random(seed)}));
        write_word(other, 36'({$random(seed), $random(seed)}));
        drive(1'b1, 1'b1, 1'b1, 1'b0, other);
        expect_at(2, 37'h0, M_OE);
        burst(base | 16'(2'($random(seed))), 1'b0);
        drive(1'b0, 1'b0, 1'b1, 1'b0, other);
        expect_at(3, {1'b1, mem[other]}, '1);
        drive(1'b1, 1'b1, 1'b1, 1'b1, other);
        drive(1'b0, 1'b1, 1'b1, 1'b1, base, 3'b110);
        expect_at(3, {1'b0, mem[other]}, M_DQ);
        drive(1'b1, 1'b1, 1'b1, 1'b1, base);
        for (int j = 0; j < 3; j++)
        begin
            drive(1'b1, 1'b0, 1'b1, 1'b1, base, {j == 0, j != 1, j == 2});
            expect_at(2, 37'h0, M_OE);
            read_word(base + 16'(j), 1'b1);
            drive(1'b1, 1'b1, 1'b1, 1'b1, base);
        end
        drive(1'b1, 1'b1, 1'b1, 1'b1, base);
        slp <= 1'b1;
        wait_sleep(1'b1);
        @(negedge clk_in);
        check({36'h0, doe}, 37'h0, '1);
        drive(1'b0, 1'b1, 1'b1, 1'b1, other);
        drive(1'b1, 1'b1, 1'b1, 1'b1, other);
        slp <= 1'b0;
        wait_sleep(1'b0);
        drive(1'b1, 1'b1, 1'b1, 1'b1, other);
        expect_at(3, {1'b1, mem[base + 16'h0002]}, '1);
        read_word(base + 16'h0003, 1'b0);
        drive(1'b1, 1'b1, 1'b1, 1'b1, base);
        do_reset(1'b0);
        burst(base | 16'(2'($random(seed))), 1'b1);
        oe_n <= 1'b1;
        repeat (3) drive(1'b1, 1'b1, 1'b1, 1'b1, base);
        drive(1'b0, 1'b1, 1'b1, 1'b1, base + 16'h0001);
        expect_at(3, {1'b0, mem[base + 16'h0001]}, '1);
        drive(1'b1, 1'b1, 1'b1, 1'b1, base);
        for (int n = 0; n < 10 && notes.size() > 0; n++)
            @(posedge clk_in);
        if (notes.size() > 0)
            miscompares++;
        end_of_test();
    end
endmodule
